// >>> hdl/aoi_audio_out.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// RL1: Unmasked request or underrun setting raises interrupt
// RL2: Sample byte write clears request and underrun
// RL3: Interrupt flag clears on service entry acknowledge
// RL4: Processor loads four bytes per request
// RL5: Software sets master clock 256 or 384 Fs
// RL6: High rate bit picks bit clock ratio
// RL7: Five bit alignment field shifts data start
// RL8: Polarity bit picks word select level for left
// RL9: Size bit picks 16 or 32 bit slots
// RL10: Format control resets to 0x08
// RL11: Source bit selects processor or decoder samples
// RL12: Pull bit enables decoder data requests
// RL13: Mask bits block request and underrun interrupts
// RL14: Enable bit turns whole interface on; code leaves register and buffer writes active when off
// RL15: Source control resets 0xb2, bit 3 zero
// RL16: Request flag sets when buffer half empty
// RL17: Underrun flag sets when buffer runs empty
// RL18: Busy flag high while buffer full; code raises it only with processor source selected
// RL19: Status read only, resets 0xc0, low zeros
// RL20: Sample byte register resets to all ones
// RL21: Divider holds five bits, resets to zero
// RL22: Software answers requests before any underrun
// RL23: Request sets at four to three, clears four to five
// RL24: Byte widened with zero low byte
// RL25: Repeat code replays sample 1,2,4,6 times
// RL26: Alignment zero MSB, one LSB, more pads zeros
// RL27: MSB first, data changes on falling bit clock
module aoi_audio_out
  import aoi_pkg::*;
#(
  parameter int VBUF_DEPTH = AOI_VBUF_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [7:0] i_sfr_addr,
  input wire logic i_sfr_wr,
  input wire logic i_sfr_rd,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_sfr_rdata,
  input wire logic [15:0] i_dec_data,
  input wire logic i_dec_valid,
  output logic o_dec_req,
  input wire logic i_global_audio_irq_enable,
  input wire logic i_irq_ack,
  output logic o_irq_flag,
  output logic o_irq_req,
  output logic o_master_clk,
  output logic o_bit_clock_out,
  output logic o_word_select_out,
  output logic o_serial_data
);
  localparam int VAW = $clog2(VBUF_DEPTH);
  localparam logic [VAW:0] VFULL = (VAW+1)'(VBUF_DEPTH);
  localparam logic [VAW:0] VLVL = (VAW+1)'(AOI_REQ_LEVEL);

  typedef struct packed {
    logic [7:0] fmt;
    logic [7:0] src;
    logic [7:0] dat;
    logic [4:0] div;
    logic req;
    logic udr;
    logic irq;
    logic [7:0] rdata;
    logic [VAW:0] vcnt;
    logic [VAW-1:0] vwp;
    logic [VAW-1:0] vrp;
    logic vstale;
    logic vhave;
    logic [2:0] vrep;
    logic [7:0] vbyte;
    logic dhalf;
    logic [15:0] dleft;
    logic [1:0][31:0] fmem;
    logic fwp;
    logic frp;
    logic [1:0] fcnt;
    logic [4:0] dcnt;
    logic mclk;
    logic [3:0] hcnt;
    logic run;
    logic bclk;
    logic ws;
    logic sdo;
    logic [31:0] frame;
    logic [5:0] idx;
  } aoi_state_type;

  aoi_state_type q;
  aoi_state_type n;
  aoi_mem_if #(.AW(VAW), .DW(8)) mb ();

  logic en, voice, wide, dat_wr, vwr, pop_v, f_ready, f_push, f_pop, tick;
  logic req_set, udr_set, busy;
  logic [31:0] f_in;
  logic [3:0] hb_n;
  logic [5:0] last;
  logic [1:0] bit_o;
  logic [7:0] sta;

  // Word select and data bit for a frame position
  function automatic logic [1:0] slot_bit(input logic [31:0] fr,
      input logic [5:0] idx, input logic wd, input logic [4:0] al,
      input logic word_select_polarity);
    logic ch;
    logic [5:0] j;
    logic [5:0] slot;
    logic [5:0] start;
    logic [5:0] k;
    logic [15:0] s;
    ch = wd ? idx[5] : idx[4];
    j = wd ? {1'b0, idx[4:0]} : {2'b00, idx[3:0]};
    slot = wd ? 6'h20 : 6'h10;
    s = ch ? fr[15:0] : fr[31:16];
    start = 6'h00;
    // RL26: Justification start point
    if (al != 5'h00 && ({1'b0, al} - 6'h01) <= (slot - 6'h10)) begin
      start = slot - 6'h10 - ({1'b0, al} - 6'h01);
    end
    k = j - start;
    // RL8: Left slot level
    slot_bit[1] = ch ? ~word_select_polarity : word_select_polarity;
    // RL27: Most significant bit first
    slot_bit[0] = (j >= start && k < 6'h10) ? s[4'hf - k[3:0]] : 1'b0;
  endfunction : slot_bit

  aoi_sample_mem #(.DEPTH(VBUF_DEPTH), .DW(8)) u_mem (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .mem_bus(mb.mem)
  );

  assign mb.wr_en = vwr;
  assign mb.wr_addr = q.vwp;
  assign mb.wr_data = i_sfr_wdata;
  assign mb.rd_addr = q.vrp;

  always_comb begin
    n = q;
    // RL14: Interface enable
    en = q.src[AOI_EN_BIT];
    // RL11: Sample source
    voice = q.src[AOI_SRCSEL_BIT];
    wide = q.fmt[AOI_SIZE_BIT];
    last = wide ? AOI_LAST_32 : AOI_LAST_16;
    // RL6: Bit clock ratio
    if (q.fmt[AOI_HLR_BIT]) begin
      hb_n = wide ? AOI_HB_384_32 : AOI_HB_384_16;
    end else begin
      hb_n = wide ? AOI_HB_256_32 : AOI_HB_256_16;
    end
    dat_wr = i_sfr_wr && i_sfr_addr == AOI_DAT_ADDR;
    vwr = dat_wr && q.vcnt != VFULL;
    // RL18: Busy while full
    busy = voice && q.vcnt == VFULL;
    sta = 8'h00;
    sta[AOI_REQ_BIT] = q.req;
    sta[AOI_UDR_BIT] = q.udr;
    sta[AOI_FULL_BIT] = busy;
    // Register writes
    if (i_sfr_wr) begin
      case (i_sfr_addr)
        AOI_FMT_ADDR: n.fmt = i_sfr_wdata;
        AOI_SRC_ADDR: begin
          n.src = i_sfr_wdata;
          // RL15: Reserved bit kept zero
          n.src[AOI_RSV_BIT] = 1'b0;
        end
        AOI_DAT_ADDR: n.dat = i_sfr_wdata;
        // RL21: Five bit divisor
        AOI_DIV_ADDR: n.div = i_sfr_wdata[4:0];
        default: n.div = q.div;
      endcase
    end
    // RL19: Status read only view
    if (i_sfr_rd) begin
      case (i_sfr_addr)
        AOI_FMT_ADDR: n.rdata = q.fmt;
        AOI_SRC_ADDR: n.rdata = q.src;
        AOI_STA_ADDR: n.rdata = sta;
        AOI_DAT_ADDR: n.rdata = q.dat;
        AOI_DIV_ADDR: n.rdata = {3'b000, q.div};
        default: n.rdata = 8'h00;
      endcase
    end
    // Voice byte fetch from sample memory
    pop_v = voice && en && !q.vhave && q.vcnt != '0 && !q.vstale;
    n.vstale = vwr | pop_v;
    if (vwr) begin
      n.vwp = q.vwp + 1'b1;
    end
    if (pop_v) begin
      n.vrp = q.vrp + 1'b1;
      n.vhave = 1'b1;
      n.vbyte = mb.rd_data;
      // RL25: Repeat factor
      case (q.src[AOI_REP_LSB +: 2])
        2'h0: n.vrep = AOI_REP_X1;
        2'h1: n.vrep = AOI_REP_X2;
        2'h2: n.vrep = AOI_REP_X4;
        default: n.vrep = AOI_REP_X6;
      endcase
    end
    if (vwr && !pop_v) begin
      n.vcnt = q.vcnt + 1'b1;
    end else if (pop_v && !vwr) begin
      n.vcnt = q.vcnt - 1'b1;
    end
    // RL16: Request at half empty
    // RL23: Set four to three
    req_set = voice && q.vcnt == VLVL && n.vcnt == VLVL - 1'b1;
    // RL17: Underrun on empty
    udr_set = voice && q.vcnt != '0 && n.vcnt == '0;
    // RL2: Byte write clears flags
    n.req = req_set | (q.req & ~(dat_wr | (q.vcnt == VLVL &&
      n.vcnt == VLVL + 1'b1)));
    n.udr = udr_set | (q.udr & ~dat_wr);
    // RL1: Raise on unmasked set
    // RL13: Source masks
    // RL3: Cleared on service entry
    n.irq = (req_set & ~q.src[AOI_RMASK_BIT]) |
      (udr_set & ~q.src[AOI_UMASK_BIT]) | (q.irq & ~i_irq_ack);
    // Two entry frame buffer feed
    f_ready = q.fcnt != 2'h2;
    // RL12: Decoder pull
    o_dec_req = en && !voice && q.src[AOI_PULL_BIT] && f_ready;
    f_push = 1'b0;
    // RL24: Zero low byte
    f_in = voice ? {q.vbyte, AOI_LOW_FILL, q.vbyte, AOI_LOW_FILL} :
      {q.dleft, i_dec_data};
    if (voice && q.vhave && f_ready) begin
      f_push = 1'b1;
      n.vrep = q.vrep - 3'h1;
      n.vhave = q.vrep != 3'h1;
    end
    if (o_dec_req && i_dec_valid) begin
      n.dhalf = ~q.dhalf;
      n.dleft = q.dhalf ? q.dleft : i_dec_data;
      f_push = q.dhalf;
    end
    // Clock generation and serializer
    f_pop = 1'b0;
    bit_o = 2'b00;
    tick = q.dcnt == q.div;
    if (!en) begin
      n.dcnt = 5'h00;
      n.mclk = 1'b0;
      n.hcnt = 4'h0;
      n.run = 1'b0;
      n.bclk = 1'b0;
      n.sdo = 1'b0;
    end else begin
      n.dcnt = tick ? 5'h00 : q.dcnt + 5'h01;
      n.mclk = tick ? ~q.mclk : q.mclk;
      if (!q.run) begin
        if (q.fcnt != 2'h0) begin
          f_pop = 1'b1;
          n.run = 1'b1;
          n.frame = q.fmem[q.frp];
          n.idx = 6'h00;
          n.hcnt = 4'h0;
          n.bclk = 1'b0;
          // RL7: Alignment from field
          bit_o = slot_bit(n.frame, 6'h00, wide,
            q.fmt[AOI_ALIGN_LSB +: 5], q.fmt[AOI_POL_BIT]);
          n.ws = bit_o[1];
          n.sdo = bit_o[0];
        end
      end else if (tick) begin
        if (q.hcnt == hb_n - 4'h1) begin
          n.hcnt = 4'h0;
          n.bclk = ~q.bclk;
          // RL27: Advance on falling edge
          if (q.bclk) begin
            // RL9: Slot length
            if (q.idx == last) begin
              n.idx = 6'h00;
              if (q.fcnt != 2'h0) begin
                f_pop = 1'b1;
                n.frame = q.fmem[q.frp];
              end else begin
                n.run = 1'b0;
              end
            end else begin
              n.idx = q.idx + 6'h01;
            end
            bit_o = slot_bit(n.frame, n.idx, wide,
              q.fmt[AOI_ALIGN_LSB +: 5], q.fmt[AOI_POL_BIT]);
            n.ws = n.run ? bit_o[1] : q.ws;
            n.sdo = n.run & bit_o[0];
          end
        end else begin
          n.hcnt = q.hcnt + 4'h1;
        end
      end
    end
    if (f_push) begin
      n.fmem[q.fwp] = f_in;
      n.fwp = ~q.fwp;
    end
    if (f_pop) begin
      n.frp = ~q.frp;
    end
    n.fcnt = q.fcnt + {1'b0, f_push} - {1'b0, f_pop};
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
      // RL10: Format control reset
      q.fmt <= AOI_FMT_RST;
      // RL15: Source control reset
      q.src <= AOI_SRC_RST;
      // RL20: Sample byte reset
      q.dat <= AOI_DAT_RST;
      q.div <= AOI_DIV_RST;
      // RL19: Status flags reset
      q.req <= AOI_STA_RST[AOI_REQ_BIT];
      q.udr <= AOI_STA_RST[AOI_UDR_BIT];
    end else begin
      q <= n;
    end
  end

  assign o_sfr_rdata = q.rdata;
  assign o_irq_flag = q.irq;
  assign o_irq_req = q.irq & i_global_audio_irq_enable;
  assign o_master_clk = q.mclk;
  assign o_bit_clock_out = q.bclk;
  assign o_word_select_out = q.ws;
  assign o_serial_data = q.sdo;

  // RL1: Interrupt follows set
  property p_irq_raise;
    @(posedge i_clk) disable iff (!i_nrst)
    (req_set && !q.src[AOI_RMASK_BIT]) |=> q.irq;
  endproperty
  a_irq_raise: assert property (p_irq_raise) // RL1
    else $error("interrupt flag not raised by request");

  // RL2: Write clears flags
  property p_write_clears;
    @(posedge i_clk) disable iff (!i_nrst)
    dat_wr |=> (!q.req && !q.udr);
  endproperty
  a_write_clears: assert property (p_write_clears) // RL2
    else $error("sample write did not clear flags");

  // RL3: Acknowledge clears flag
  property p_ack_clears;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_irq_ack && !req_set && !udr_set) |=> !o_irq_flag;
  endproperty
  a_ack_clears: assert property (p_ack_clears) // RL3
    else $error("interrupt flag survived acknowledge");

  // RL14: Disabled clocks idle
  property p_disable_idle;
    @(posedge i_clk) disable iff (!i_nrst)
    !q.src[AOI_EN_BIT] |=> (!o_bit_clock_out && !o_master_clk);
  endproperty
  a_disable_idle: assert property (p_disable_idle) // RL14
    else $error("clocks running while disabled");

  // RL15: Reserved bit reads zero
  property p_rsv_zero;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && i_sfr_addr == AOI_SRC_ADDR) |=> !o_sfr_rdata[AOI_RSV_BIT];
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) // RL15
    else $error("reserved control bit read as one");

  // RL18: Busy read when full
  property p_busy_read;
    @(posedge i_clk) disable iff (!i_nrst)
    (i_sfr_rd && i_sfr_addr == AOI_STA_ADDR) |=>
      (o_sfr_rdata[AOI_FULL_BIT] == $past(busy) && o_sfr_rdata[4:0] == 5'h00);
  endproperty
  a_busy_read: assert property (p_busy_read) // RL18
    else $error("status read wrong busy or reserved bits");

  // RL23: Request on four to three
  property p_req_level;
    @(posedge i_clk) disable iff (!i_nrst)
    (voice && q.vcnt == VLVL ##1 q.vcnt == VLVL - 1'b1) |-> q.req;
  endproperty
  a_req_level: assert property (p_req_level) // RL23
    else $error("request flag missing at half empty");

  // RL17: Underrun on empty
  property p_udr_empty;
    @(posedge i_clk) disable iff (!i_nrst)
    (voice && q.vcnt != '0 ##1 q.vcnt == '0) |-> q.udr;
  endproperty
  a_udr_empty: assert property (p_udr_empty) // RL17
    else $error("underrun flag missing on empty buffer");
endmodule : aoi_audio_out
`default_nettype wire

// >>> hdl/aoi_mem_if.sv
`timescale 1ns/10ps
`default_nettype none
interface aoi_mem_if #(
  parameter int AW = 3,
  parameter int DW = 8
);
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data,
    output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data,
    input rd_addr, output rd_data);
endinterface : aoi_mem_if
`default_nettype wire

// >>> hdl/aoi_pkg.sv
package aoi_pkg;
  // Register addresses
  localparam logic [7:0] AOI_FMT_ADDR = 8'h9a;
  localparam logic [7:0] AOI_SRC_ADDR = 8'h9b;
  localparam logic [7:0] AOI_STA_ADDR = 8'h9c;
  localparam logic [7:0] AOI_DAT_ADDR = 8'h9d;
  localparam logic [7:0] AOI_DIV_ADDR = 8'hec;
  // Values after reset
  localparam logic [7:0] AOI_FMT_RST = 8'h08;
  localparam logic [7:0] AOI_SRC_RST = 8'hb2;
  localparam logic [7:0] AOI_STA_RST = 8'hc0;
  localparam logic [7:0] AOI_DAT_RST = 8'hff;
  localparam logic [4:0] AOI_DIV_RST = 5'h00;
  // Format control fields
  localparam int AOI_HLR_BIT = 0;
  localparam int AOI_SIZE_BIT = 1;
  localparam int AOI_POL_BIT = 2;
  localparam int AOI_ALIGN_LSB = 3;
  // Source control fields
  localparam int AOI_EN_BIT = 0;
  localparam int AOI_REP_LSB = 1;
  localparam int AOI_RSV_BIT = 3;
  localparam int AOI_UMASK_BIT = 4;
  localparam int AOI_RMASK_BIT = 5;
  localparam int AOI_PULL_BIT = 6;
  localparam int AOI_SRCSEL_BIT = 7;
  // Status fields
  localparam int AOI_REQ_BIT = 7;
  localparam int AOI_UDR_BIT = 6;
  localparam int AOI_FULL_BIT = 5;
  // Voice buffer
  localparam int AOI_VBUF_DEPTH = 8;
  localparam int AOI_REQ_LEVEL = 4;
  localparam logic [7:0] AOI_LOW_FILL = 8'h00;
  // Repeat counts per rate code
  localparam logic [2:0] AOI_REP_X1 = 3'h1;
  localparam logic [2:0] AOI_REP_X2 = 3'h2;
  localparam logic [2:0] AOI_REP_X4 = 3'h4;
  localparam logic [2:0] AOI_REP_X6 = 3'h6;
  // Master clock half periods per half bit
  localparam logic [3:0] AOI_HB_256_16 = 4'h8;
  localparam logic [3:0] AOI_HB_256_32 = 4'h4;
  localparam logic [3:0] AOI_HB_384_16 = 4'hc;
  localparam logic [3:0] AOI_HB_384_32 = 4'h6;
  localparam logic [5:0] AOI_LAST_16 = 6'h1f;
  localparam logic [5:0] AOI_LAST_32 = 6'h3f;
endpackage : aoi_pkg

// >>> hdl/aoi_sample_mem.sv
`timescale 1ns/10ps
`default_nettype none
module aoi_sample_mem
  import aoi_pkg::*;
#(
  parameter int DEPTH = AOI_VBUF_DEPTH,
  parameter int DW = 8
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  aoi_mem_if.mem mem_bus
);
  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] cells;
    logic [DW-1:0] rd;
  } aoi_mem_state_type;

  aoi_mem_state_type q;
  aoi_mem_state_type n;

  always_comb begin
    n = q;
    if (mem_bus.wr_en) begin
      n.cells[mem_bus.wr_addr] = mem_bus.wr_data;
    end
    n.rd = q.cells[mem_bus.rd_addr];
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign mem_bus.rd_data = q.rd;
endmodule : aoi_sample_mem
`default_nettype wire

// >>> tb/aoi_dac_model.sv
`timescale 1ns/10ps
`default_nettype none
module aoi_dac_model (
  input wire logic i_bclk,
  input wire logic i_ws,
  input wire logic i_sdo,
  input wire logic i_wide
);
  logic [31:0] words[$];
  logic wsq[$];
  logic [31:0] sh = 32'h0;
  logic ws_p = 1'b0;
  int cnt = 0;
  time last = 0;
  time period = 0;
  always @(posedge i_bclk) begin
    period = $time - last;
    last = $time;
    if (i_ws !== ws_p) begin
      cnt = 1;
      sh = {31'h0, i_sdo};
    end else begin
      cnt = cnt + 1;
      sh = {sh[30:0], i_sdo};
    end
    ws_p = i_ws;
    if (cnt == (i_wide ? 32 : 16)) begin
      words.push_back(sh);
      wsq.push_back(i_ws);
      cnt = 0;
    end
  end
endmodule : aoi_dac_model
`default_nettype wire

// >>> tb/test_aoi_audio_out.sv
`timescale 1ns/10ps
`default_nettype none
module test_aoi_audio_out;
  import aoi_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic [15:0] dec_d = 16'h0000;
  logic dec_v = 1'b0;
  logic gie = 1'b1;
  logic ack = 1'b0;
  logic wide = 1'b0;
  logic [7:0] rdata;
  logic dec_req, irq_flag, irq_req, mclk, bclk, ws, sdo;
  logic [7:0] rv, b;
  logic [7:0] ra[6] = '{AOI_FMT_ADDR, AOI_SRC_ADDR, AOI_STA_ADDR,
    AOI_DAT_ADDR, AOI_DIV_ADDR, 8'h00};
  logic [7:0] re[6] = '{8'h08, 8'hb2, 8'hc0, 8'hff, 8'h00, 8'h00};
  int reps[4] = '{1, 2, 4, 6};
  int err_total = 0;
  int cmp_count = 0;
  int base = 0;
  int stalls = 0;
  int highs = 0;
  always #50 clk = ~clk;
  aoi_audio_out DUT (.i_clk(clk), .i_nrst(nrst), .i_sfr_addr(addr),
    .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
    .o_sfr_rdata(rdata), .i_dec_data(dec_d), .i_dec_valid(dec_v),
    .o_dec_req(dec_req), .i_global_audio_irq_enable(gie),
    .i_irq_ack(ack), .o_irq_flag(irq_flag), .o_irq_req(irq_req),
    .o_master_clk(mclk), .o_bit_clock_out(bclk),
    .o_word_select_out(ws), .o_serial_data(sdo));
  aoi_dac_model u_dac (.i_bclk(bclk), .i_ws(ws), .i_sdo(sdo),
    .i_wide(wide));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  task automatic fail();
    err_total++;
    report_and_stop();
  endtask : fail
  task automatic chk(input string name, input logic [31:0] exp,
      input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
    @(negedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    @(negedge clk);
  endtask : rd_reg
  task automatic wait_sta(input logic [7:0] m, input logic [7:0] v);
    int i;
    i = 0;
    rd_reg(AOI_STA_ADDR, rv);
    while ((rv & m) !== v && i < 3000) begin
      rd_reg(AOI_STA_ADDR, rv);
      i++;
    end
    if (i >= 3000) fail();
  endtask : wait_sta
  task automatic wait_words(input int n);
    int i;
    i = 0;
    while (u_dac.words.size() < n && i < 40000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 40000) fail();
  endtask : wait_words
  task automatic dec_put(input logic [15:0] d);
    int i;
    i = 0;
    dec_d = d;
    dec_v = 1'b1;
    while (dec_req !== 1'b1 && i < 20000) begin
      @(negedge clk);
      i++;
    end
    if (i >= 20000) fail();
    stalls += i;
    @(negedge clk);
  endtask : dec_put
  initial begin
    repeat (12) @(negedge clk);
    nrst = 1'b1;
    for (int k = 0; k < 6; k++) begin
      rd_reg(ra[k], rv);
      chk("reset", re[k], rv);
    end
    chk("irq", 0, irq_flag);
    wr_reg(AOI_DIV_ADDR, 8'hff);
    rd_reg(AOI_DIV_ADDR, rv);
    chk("div", 8'h1f, rv);
    wr_reg(AOI_SRC_ADDR, 8'h38);
    rd_reg(AOI_SRC_ADDR, rv);
    chk("src", 8'h30, rv);
    wr_reg(AOI_STA_ADDR, 8'h00);
    rd_reg(AOI_STA_ADDR, rv);
    chk("sta", 8'hc0, rv);
    wr_reg(AOI_FMT_ADDR, 8'h0f);
    rd_reg(AOI_FMT_ADDR, rv);
    chk("fmt", 8'h0f, rv);
    // Voice path, 256 Fs, 16-bit, left on low
    wr_reg(AOI_DIV_ADDR, 8'h00);
    wr_reg(AOI_FMT_ADDR, 8'h00);
    wr_reg(AOI_SRC_ADDR, 8'h80);
    for (int k = 0; k < 8; k++) wr_reg(AOI_DAT_ADDR, 8'h10 + 8'(k));
    rd_reg(AOI_STA_ADDR, rv);
    chk("sta", 8'h20, rv);
    wr_reg(AOI_DAT_ADDR, 8'hee);
    rd_reg(AOI_STA_ADDR, rv);
    chk("sta", 8'h20, rv);
    wr_reg(AOI_SRC_ADDR, 8'h81);
    wait_sta(8'h80, 8'h80);
    chk("irq", 1, irq_flag);
    chk("irq_req", 1, irq_req);
    gie = 1'b0;
    @(negedge clk);
    chk("irq_req", 0, irq_req);
    gie = 1'b1;
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    @(negedge clk);
    chk("irq", 0, irq_flag);
    wr_reg(AOI_SRC_ADDR, 8'hb1);
    for (int k = 0; k < 4; k++) wr_reg(AOI_DAT_ADDR, 8'h30 + 8'(k));
    rd_reg(AOI_STA_ADDR, rv);
    chk("sta", 8'h00, rv);
    wait_sta(8'hc0, 8'hc0);
    chk("irq", 0, irq_flag);
    wait_words(24);
    for (int k = 0; k < 24; k++) begin
      b = (k < 16) ? 8'h10 + 8'(k / 2) : 8'h28 + 8'(k / 2);
      chk("word", {b, 8'h00}, u_dac.words[k][15:0]);
      chk("ws", {31'h0, k[0]}, {31'h0, u_dac.wsq[k]});
    end
    // Let the last 16-bit frame end before reformatting
    repeat (40) @(negedge clk);
    // 384 Fs, 32-bit slots, LSB justified, left on high
    wide = 1'b1;
    wr_reg(AOI_DIV_ADDR, 8'h01);
    wr_reg(AOI_FMT_ADDR, 8'h0f);
    b[0] = mclk;
    repeat (2) @(negedge clk);
    chk("mclk", 1, b[0] ^ mclk);
    base = 24;
    for (int c = 0; c < 4; c++) begin
      wr_reg(AOI_SRC_ADDR, 8'hb1 | 8'(c << 1));
      wr_reg(AOI_DAT_ADDR, 8'ha0 + 8'(c));
      wait_words(base + 2 * reps[c]);
      for (int j = 0; j < 2 * reps[c]; j++) begin
        chk("word", {16'h0, 8'ha0 + 8'(c), 8'h00},
          u_dac.words[base + j]);
        chk("ws", {31'h0, ~j[0]}, {31'h0, u_dac.wsq[base + j]});
      end
      base += 2 * reps[c];
    end
    repeat (3000) @(negedge clk);
    chk("count", base, u_dac.words.size());
    chk("period", 2400, u_dac.period);
    // Wider LSB justification at 256 Fs, unmasked underrun
    wr_reg(AOI_FMT_ADDR, 8'h16);
    wr_reg(AOI_SRC_ADDR, 8'ha1);
    wr_reg(AOI_DAT_ADDR, 8'hc5);
    wait_words(base + 2);
    for (int j = 0; j < 2; j++) begin
      chk("word", 32'h0001_8a00, u_dac.words[base + j]);
    end
    chk("period", 1600, u_dac.period);
    chk("irq", 1, irq_flag);
    ack = 1'b1;
    @(negedge clk);
    ack = 1'b0;
    base += 2;
    repeat (40) @(negedge clk);
    // Decoder path through the two-entry buffer, 384 Fs
    wide = 1'b0;
    wr_reg(AOI_DIV_ADDR, 8'h00);
    wr_reg(AOI_FMT_ADDR, 8'h01);
    wr_reg(AOI_SRC_ADDR, 8'h41);
    chk("dec_req", 1, dec_req);
    b[0] = mclk;
    @(negedge clk);
    chk("mclk", 1, b[0] ^ mclk);
    for (int k = 0; k < 10; k++) dec_put(16'h1234 + 16'h1111 * 16'(k));
    dec_v = 1'b0;
    chk("stall", 1, stalls > 0);
    wait_words(base + 6);
    for (int k = 0; k < 6; k++) begin
      chk("dec", 16'h1234 + 16'h1111 * 16'(k),
        u_dac.words[base + k][15:0]);
      chk("ws", {31'h0, k[0]}, {31'h0, u_dac.wsq[base + k]});
    end
    chk("period", 2400, u_dac.period);
    wr_reg(AOI_SRC_ADDR, 8'h01);
    chk("dec_req", 0, dec_req);
    wr_reg(AOI_SRC_ADDR, 8'hc1);
    chk("dec_req", 0, dec_req);
    wr_reg(AOI_SRC_ADDR, 8'h40);
    repeat (4) @(negedge clk);
    for (int k = 0; k < 200; k++) begin
      @(negedge clk);
      highs += (bclk !== 1'b0);
    end
    chk("bclk", 0, highs);
    report_and_stop();
  end
endmodule : test_aoi_audio_out
`default_nettype wire
